// ===== pkg/adpp_pkg.sv
// shared types and constants of the dual converter parallel port
package adpp_pkg;
	localparam int          DATA_W      = 12;
	localparam int          CONV_CLOCKS = 16;
	localparam int          FIFO_DEPTH  = 2;
	localparam logic        PAIR_ZERO   = 1'b0;
	localparam logic        HALF_ONE    = 1'b0;
	localparam logic        HALF_TWO    = 1'b1;
	localparam logic [11:0] CODE_RST    = 12'h000;

	// codes presented by the analog core, per half and per input
	typedef struct packed {
		logic [DATA_W-1:0] half_one_input_zero;
		logic [DATA_W-1:0] half_one_input_one;
		logic [DATA_W-1:0] half_two_input_zero;
		logic [DATA_W-1:0] half_two_input_one;
	} adpp_codes_t;

	// one finished conversion: both halves of one input pair
	typedef struct packed {
		logic              pair;
		logic [DATA_W-1:0] half_one;
		logic [DATA_W-1:0] half_two;
	} adpp_result_t;

	typedef enum logic [1:0] {
		ADPP_IDLE    = 2'b00,
		ADPP_CONVERT = 2'b01,
		ADPP_STORE   = 2'b10
	} adpp_state_t;
endpackage : adpp_pkg

// ===== hdl/adpp_top.sv
// control and parallel output port of a dual simultaneous-sampling converter
module adpp_top
	import adpp_pkg::*;
#(
	parameter int CONV_CLOCKS_P = adpp_pkg::CONV_CLOCKS
) (
	input  wire logic                      ref_clk,
	input  wire logic                      nrst,
	input  wire logic                      conv_clk,
	input  wire logic                      conversion_strobe_n,
	input  wire logic                      pair_select,
	input  wire logic                      chip_select_n,
	input  wire logic                      read_strobe_n,
	input  wire adpp_pkg::adpp_codes_t     analog_codes,
	output logic                           busy,
	output logic [adpp_pkg::DATA_W-1:0]    result_data,
	output logic                           result_oe
);
	import adpp_pkg::*;

	// ==========================================================
	// pin edge detection
	logic conv_clk_d_r;
	logic strobe_d_r;
	logic rd_d_r;
	logic conv_tick;
	logic strobe_fall;
	logic rd_fall;

	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			conv_clk_d_r <= 1'b0;
			strobe_d_r   <= 1'b1;
			rd_d_r       <= 1'b1;
		end else begin
			conv_clk_d_r <= conv_clk;
			strobe_d_r   <= conversion_strobe_n;
			rd_d_r       <= read_strobe_n;
		end
	end

	assign conv_tick   = conv_clk & ~conv_clk_d_r;
	assign strobe_fall = strobe_d_r & ~conversion_strobe_n;
	assign rd_fall     = rd_d_r & ~read_strobe_n;

	// ==========================================================
	// conversion sequencer
	localparam int CNT_W = $clog2(CONV_CLOCKS_P + 1);
	localparam logic [CNT_W-1:0] CNT_LAST = CNT_W'(CONV_CLOCKS_P - 1);

	adpp_state_t        state_r;
	logic [CNT_W-1:0]   clk_cnt_r;
	adpp_result_t       held_r;
	logic               push_valid;
	logic               push_ready;

	assign push_valid = (state_r == ADPP_STORE);

	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			state_r   <= ADPP_IDLE;
			clk_cnt_r <= '0;
		end else begin
			case (state_r)
				ADPP_IDLE: begin
					if (strobe_fall) begin
						state_r   <= ADPP_CONVERT;
						clk_cnt_r <= '0;
					end
				end
				ADPP_CONVERT: begin
					// one sample period of sixteen converter clocks
					if (conv_tick) begin
						if (clk_cnt_r == CNT_LAST) begin
							state_r <= ADPP_STORE;
						end else begin
							clk_cnt_r <= clk_cnt_r + 1'b1;
						end
					end
				end
				ADPP_STORE: begin
					if (push_ready) begin
						state_r <= ADPP_IDLE;
					end
				end
				default: begin
					state_r <= ADPP_IDLE;
				end
			endcase
		end
	end

	// sample-and-hold: both halves captured together at the strobe
	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			held_r <= '0;
		end else if (state_r == ADPP_IDLE && strobe_fall) begin
			held_r.pair <= pair_select;
			if (pair_select == PAIR_ZERO) begin
				held_r.half_one <= analog_codes.half_one_input_zero;
				held_r.half_two <= analog_codes.half_two_input_zero;
			end else begin
				held_r.half_one <= analog_codes.half_one_input_one;
				held_r.half_two <= analog_codes.half_two_input_one;
			end
		end
	end

	// busy also covers a stalled store; unread results in the store banks are still overwritten by a later pop of the same pair
	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			busy <= 1'b0;
		end else if (state_r == ADPP_IDLE && strobe_fall) begin
			busy <= 1'b1;
		end else if (push_valid && push_ready) begin
			busy <= 1'b0;
		end
	end

	// ==========================================================
	// two-entry result buffer
	adpp_result_t             fifo_mem_r [FIFO_DEPTH];
	logic                     wr_ptr_r;
	logic                     rd_ptr_r;
	logic [1:0]               fill_r;
	logic                     pop_valid;
	logic                     pop_ready;
	logic                     do_push;
	logic                     do_pop;

	assign push_ready = (fill_r != 2'(FIFO_DEPTH));
	assign pop_valid  = (fill_r != 2'h0);
	assign do_push    = push_valid & push_ready;
	assign do_pop     = pop_valid & pop_ready;

	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			wr_ptr_r <= 1'b0;
			rd_ptr_r <= 1'b0;
			fill_r   <= 2'h0;
		end else begin
			if (do_push) begin
				wr_ptr_r <= ~wr_ptr_r;
			end
			if (do_pop) begin
				rd_ptr_r <= ~rd_ptr_r;
			end
			case ({do_push, do_pop})
				2'b10:   fill_r <= fill_r + 2'h1;
				2'b01:   fill_r <= fill_r - 2'h1;
				default: fill_r <= fill_r;
			endcase
		end
	end

	always_ff @(posedge ref_clk) begin
		if (do_push) begin
			fifo_mem_r[wr_ptr_r] <= held_r;
		end
	end

	// ==========================================================
	// stored results, one bank per half, one entry per input
	logic [DATA_W-1:0] store_one_r [2];
	logic [DATA_W-1:0] store_two_r [2];
	adpp_result_t      head;
	logic              half_sel_r;

	assign head = fifo_mem_r[rd_ptr_r];
	// hold off updates between the two strobes; an update in the same cycle as the first strobe still splits the halves
	assign pop_ready = (half_sel_r == HALF_ONE);

	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			store_one_r[0] <= CODE_RST;
			store_one_r[1] <= CODE_RST;
			store_two_r[0] <= CODE_RST;
			store_two_r[1] <= CODE_RST;
		end else if (do_pop) begin
			store_one_r[head.pair] <= head.half_one;
			store_two_r[head.pair] <= head.half_two;
		end
	end

	// ==========================================================
	// parallel read port
	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			half_sel_r  <= HALF_ONE;
			result_oe   <= 1'b0;
			result_data <= CODE_RST;
		end else if (chip_select_n) begin
			half_sel_r <= HALF_ONE;
			result_oe  <= 1'b0;
		end else if (rd_fall) begin
			result_oe <= 1'b1;
			if (half_sel_r == HALF_ONE) begin
				result_data <= store_one_r[pair_select];
				half_sel_r  <= HALF_TWO;
			end else begin
				result_data <= store_two_r[pair_select];
				half_sel_r  <= HALF_ONE;
			end
		end
	end
endmodule : adpp_top

// ===== bench/adpp_asserts.sv
// pin-level assertions for the converter port
module adpp_asserts (
	input wire logic                     ref_clk,
	input wire logic                     nrst,
	input wire logic                     conversion_strobe_n,
	input wire logic                     chip_select_n,
	input wire logic                     read_strobe_n,
	input wire logic                     busy,
	input wire logic [adpp_pkg::DATA_W-1:0] result_data,
	input wire logic                     result_oe
);
	timeunit 1ns;
	timeprecision 100ps;
	default clocking @(posedge ref_clk); endclocking
	default disable iff (!nrst);
	sequence s_start; $fell(conversion_strobe_n) && !busy; endsequence
	sequence s_read; $fell(read_strobe_n) && !chip_select_n; endsequence
	property p_busy_rise; s_start |=> busy; endproperty
	property p_busy_hold; $rose(busy) |-> busy[*4]; endproperty
	property p_busy_quiet; !busy && !$fell(conversion_strobe_n) |=> !busy; endproperty
	property p_oe_read; s_read |=> result_oe; endproperty
	property p_oe_drop; chip_select_n |=> !result_oe; endproperty
	// data may only move on an accepted read strobe
	property p_data_hold; !($fell(read_strobe_n) && !chip_select_n) |=> $stable(result_data); endproperty
	a_busy_rise: assert property (p_busy_rise) else $error("busy late");
	a_busy_hold: assert property (p_busy_hold) else $error("busy short");
	a_busy_quiet: assert property (p_busy_quiet) else $error("busy spurious");
	a_oe_read: assert property (p_oe_read) else $error("no drive");
	a_oe_drop: assert property (p_oe_drop) else $error("drive unselected");
	a_data_hold: assert property (p_data_hold) else $error("data moved");
endmodule : adpp_asserts

bind adpp_top adpp_asserts u_chk (.ref_clk(ref_clk), .nrst(nrst), .conversion_strobe_n(conversion_strobe_n),
	.chip_select_n(chip_select_n), .read_strobe_n(read_strobe_n), .busy(busy), .result_data(result_data),
	.result_oe(result_oe));

// ===== bench/adpp_host.sv
// host side model: makes the converter clock
module adpp_host (
	output logic conv_clk
);
	timeunit 1ns;
	timeprecision 100ps;
	// free running; the offset keeps it out of phase with ref_clk
	initial begin
		conv_clk = 1'b0;
		#3;
		forever #10 conv_clk = ~conv_clk;
	end
endmodule : adpp_host

// ===== bench/adpp_top_tb.sv
// self-checking bench of the converter port
module adpp_top_tb;
	timeunit 1ns;
	timeprecision 100ps;
	import adpp_pkg::*;
	logic ref_clk = 1'b0, nrst = 1'b0, conversion_strobe_n = 1'b1, pair_select = 1'b0;
	logic chip_select_n = 1'b1, read_strobe_n = 1'b1, conv_clk, busy, result_oe;
	logic [DATA_W-1:0] result_data;
	adpp_codes_t analog_codes = {12'h1a0, 12'h1a1, 12'h2b0, 12'h2b1};
	int n_fail = 0, checked = 0, cyc = 0;
	logic ck_d = 1'b0;
	int ticks = 0;
	adpp_host host (.conv_clk(conv_clk));
	adpp_top #(.CONV_CLOCKS_P(CONV_CLOCKS)) uut (.ref_clk(ref_clk), .nrst(nrst), .conv_clk(conv_clk),
		.conversion_strobe_n(conversion_strobe_n), .pair_select(pair_select), .chip_select_n(chip_select_n),
		.read_strobe_n(read_strobe_n), .analog_codes(analog_codes), .busy(busy), .result_data(result_data),
		.result_oe(result_oe));
	initial forever #2.5 ref_clk = ~ref_clk;
	// converter clock rises seen while busy, taken at the same edges the port samples
	always @(posedge ref_clk) begin
		ck_d <= conv_clk;
		if (busy && conv_clk && !ck_d) ticks <= ticks + 1;
	end
	always @(posedge ref_clk) if (++cyc == 3000) begin
		n_fail++;
		conclude();
	end
	task chk(input logic [11:0] s, input logic [11:0] e);
		checked++;
		if (s !== e) begin
			n_fail++;
			$display("mismatch %0t seen %h want %h", $time, s, e);
		end
	endtask : chk
	// a second strobe fall while busy must not restart anything
	task conv(input logic p);
		int t0;
		@(posedge ref_clk); #1;
		t0 = ticks;
		pair_select = p;
		conversion_strobe_n = 1'b0;
		repeat (2) @(posedge ref_clk); #1;
		chk(busy, 1'b1);
		conversion_strobe_n = 1'b1;
		@(posedge ref_clk); #1;
		conversion_strobe_n = 1'b0;
		for (int i = 0; i < 300 && busy; i++) begin
			@(posedge ref_clk); #1;
		end
		conversion_strobe_n = 1'b1;
		repeat (4) @(posedge ref_clk); #1;
		chk(busy, 1'b0);
		chk(12'(ticks - t0), 12'(CONV_CLOCKS));
	endtask : conv
	// strobe is raised and an edge passes before each fall, so every fall is seen
	task rd(input logic p, input logic [11:0] a, input logic [11:0] b);
		@(posedge ref_clk); #1;
		pair_select = p;
		chip_select_n = 1'b0;
		for (int i = 0; i < 2; i++) begin
			@(posedge ref_clk); #1;
			read_strobe_n = 1'b0;
			repeat (2) @(posedge ref_clk); #1;
			chk(result_oe, 1'b1);
			chk(result_data, i ? b : a);
			read_strobe_n = 1'b1;
		end
		@(posedge ref_clk); #1;
		chip_select_n = 1'b1;
		read_strobe_n = 1'b0;
		repeat (2) @(posedge ref_clk); #1;
		chk(result_oe, 1'b0);
		chk(result_data, b);
		read_strobe_n = 1'b1;
	endtask : rd
	task t_pairs;
		conv(1'b0);
		conv(1'b1);
		rd(1'b0, 12'h1a0, 12'h2b0);
		rd(1'b1, 12'h1a1, 12'h2b1);
	endtask : t_pairs
	task conclude;
		$display("checks %0d fails %0d", checked, n_fail);
		if (n_fail == 0 && checked > 0) $display("verification passed");
		else $display("verification failed");
		$finish;
	endtask : conclude
	initial begin
		repeat (20) @(posedge ref_clk);
		#1 nrst = 1'b1;
		t_pairs();
		conclude();
	end
endmodule : adpp_top_tb
